//--- inc/scsi_diag_defs.svh
`ifndef SCSI_DIAG_DEFS_SVH
`define SCSI_DIAG_DEFS_SVH

// clock and selection timeout
`define CLK_PERIOD_NS   10
`define SEL_TIMEOUT_US  250
`define SEL_TIMEOUT_CYC ((`SEL_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`define TMO_W           25

// descriptor block contents
`define OPC_SEND_DIAG   8'h1D
`define ZERO_BYTE       8'h00
`define SELF_TEST_BITS  5'h04
`define NO_TEST_BITS    5'h00
`define VCB_PAD         6'h00
`define CDB_LEN         3'h6
`define IDX_STEP        3'h1
`define TMO_STEP        25'h0000001

// selection id pattern and identify message
`define ID_BIT          8'h01
`define IDENTIFY_BASE   8'h80
`define LUN_PAD         5'h00

// bus phases as {msg, cd, io}
`define PH_MSG_OUT      3'h6
`define PH_CMD          3'h2
`define PH_STATUS       3'h3
`define PH_MSG_IN       3'h7

`endif

//--- inc/scsi_diag_pkg.sv
package scsi_diag_pkg;
`include "scsi_diag_defs.svh"

   // host commands handled here
   typedef enum logic [1:0] {
      cmd_sel_atn   = 2'b00,
      cmd_sel_plain = 2'b01,
      cmd_send_diag = 2'b10
   } cmd_code_t;

   // answer codes
   typedef enum logic [1:0] {
      err_none               = 2'b00,
      selection_failed_error = 2'b01,
      argument_error         = 2'b10,
      unexpected_phase_error = 2'b11
   } err_code_t;

   // parsed host command line
   typedef struct packed {
      cmd_code_t   code;
      logic        val_present;
      logic        val_ovf;
      logic [7:0]  val;
      logic        len_present;
      logic        len_ovf;
      logic [15:0] len;
      logic        trailing;
   } host_cmd_t;

   // settings made by earlier commands
   typedef struct packed {
      logic [2:0] tid;
      logic [2:0] lun;
      logic [1:0] vcb;
   } cfg_t;

   // answer to the host
   typedef struct packed {
      err_code_t  err;
      logic [7:0] status;
      logic [7:0] msg_in;
   } result_t;

   // scsi bus inputs, true-high
   typedef struct packed {
      logic       bsy;
      logic       req;
      logic       msg;
      logic       cd;
      logic       io;
      logic [7:0] data;
   } bus_in_t;

   // sequencer states
   typedef enum logic [1:0] {
      st_idle     = 2'b00,
      st_select   = 2'b01,
      st_phase    = 2'b10,
      st_ack_wait = 2'b11
   } seq_state_t;

   // whole sequencer state
   typedef struct packed {
      seq_state_t           state;
      cmd_code_t            cmd;
      logic                 busy;
      logic                 done;
      result_t              result;
      logic                 sel;
      logic                 atn;
      logic                 ack;
      logic [7:0]           data_out;
      logic                 data_oe;
      logic [5:0][7:0]      cdb;
      logic [2:0]           idx;
      logic                 got_msgin;
      logic [`TMO_W-1:0]    tmo;
   } ctrl_t;

endpackage

//--- hw/bus_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser, one chain per bit
module bus_sync #(
   parameter int W = 13
) (
   // clock, reset, enable
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   // raw and synchronised levels
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_q;   // first stage, read only by second stage

   // one chain per bit; frozen while enable is low
   for (genvar i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge core_clk or negedge rst_n) begin
         if (!rst_n) begin
            meta_q[i] <= 1'b0;
            q[i]      <= 1'b0;
         end else if (ce) begin
            meta_q[i] <= d[i];
            q[i]      <= meta_q[i];
         end
      end
   end
endmodule // bus_sync

//--- hw/scsi_diag_seq.sv
`timescale 1ns/1ps
`include "scsi_diag_defs.svh"
module scsi_diag_seq
   import scsi_diag_pkg::*;
#(
   parameter int unsigned SEL_TMO_CYC = `SEL_TIMEOUT_CYC
) (
   // clock, reset, enable
   input  wire logic      core_clk,
   input  wire logic      rst_n,
   input  wire logic      ce,
   // host command
   input  wire logic      cmd_valid,
   input  wire host_cmd_t cmd,
   input  wire cfg_t      cfg,
   // host answer
   output logic           busy,
   output logic           done,
   output result_t        result,
   // scsi bus
   input  wire bus_in_t   bus_in,
   output logic           sel_out,
   output logic           atn_out,
   output logic           ack_out,
   output logic [7:0]     data_out,
   output logic           data_oe
);
   // last count before the selection attempt is given up
   localparam logic [`TMO_W-1:0] TMO_LAST = `TMO_W'(SEL_TMO_CYC - 1);

   ctrl_t                     q;        // registered state
   ctrl_t                     d;        // next state
   logic [$bits(bus_in_t)-1:0] b_vec;   // synchronised bus bits
   bus_in_t                   b;        // same, as fields
   logic [2:0]                phase;    // {msg, cd, io}
   logic                      accept;   // command taken this cycle
   logic                      arg_bad;  // command line rejected
   logic                      val_zero; // diagnostic value is zero
   logic [7:0]                ident;    // identify message byte

   // bus pins come from another party, so they pass two flops
   bus_sync #(
      .W ($bits(bus_in_t))
   ) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .ce       (ce),
      .d        (bus_in),
      .q        (b_vec)
   );

   assign b        = bus_in_t'(b_vec);
   assign phase    = {b.msg, b.cd, b.io};
   assign accept   = cmd_valid && (q.state == st_idle);
   assign val_zero = (cmd.val == `ZERO_BYTE);
   assign ident    = `IDENTIFY_BASE | {`LUN_PAD, q.cdb[1][7:5]};

   // argument checks on the parsed command line
   always_comb begin
      if (cmd.code == cmd_send_diag) begin
         arg_bad = cmd.trailing || !cmd.val_present
                || cmd.val_ovf || cmd.len_ovf;
         if (val_zero && !cmd.len_present) begin
            arg_bad = 1'b1;
         end
         if (!val_zero && cmd.len_present) begin
            arg_bad = 1'b1;
         end
      end else begin
         // selects take no argument at all; bad codes land here too
         arg_bad = cmd.trailing || (cmd.code != cmd_sel_atn
                && cmd.code != cmd_sel_plain);
      end
   end

   // next-state logic
   always_comb begin
      d      = q;
      d.done = 1'b0;
      unique case (q.state)
         // wait for a command and check it
         st_idle: begin
            if (cmd_valid) begin
               d.cmd       = cmd.code;
               d.result    = '0;
               d.got_msgin = 1'b0;
               if (arg_bad) begin
                  d.done       = 1'b1;
                  d.result.err = argument_error;
               end else begin
                  // descriptor built now so it cannot drift mid-command
                  d.cdb[0] = `OPC_SEND_DIAG;
                  d.cdb[1] = {cfg.lun, val_zero ?
                              `NO_TEST_BITS : `SELF_TEST_BITS};
                  d.cdb[2] = `ZERO_BYTE;
                  d.cdb[3] = val_zero ? cmd.len[15:8] : `ZERO_BYTE;
                  d.cdb[4] = val_zero ? cmd.len[7:0] : `ZERO_BYTE;
                  d.cdb[5] = {cfg.vcb, `VCB_PAD};
                  // high-level command always asks for message-out
                  d.atn      = (cmd.code != cmd_sel_plain);
                  d.sel      = 1'b1;
                  d.data_out = `ID_BIT << cfg.tid;
                  d.data_oe  = 1'b1;
                  d.tmo      = '0;
                  d.idx      = '0;
                  d.busy     = 1'b1;
                  d.state    = st_select;
               end
            end
         end
         // selection: wait for the target to raise busy
         st_select: begin
            if (b.bsy) begin
               d.sel     = 1'b0;
               d.data_oe = 1'b0;
               if (q.cmd == cmd_send_diag) begin
                  d.state = st_phase;
               end else begin
                  // attention stays up for the low-level sequence
                  d.done  = 1'b1;
                  d.busy  = 1'b0;
                  d.state = st_idle;
               end
            end else if (q.tmo == TMO_LAST) begin
               d.sel        = 1'b0;
               d.atn        = 1'b0;
               d.data_oe    = 1'b0;
               d.done       = 1'b1;
               d.busy       = 1'b0;
               d.result.err = selection_failed_error;
               d.state      = st_idle;
            end else begin
               d.tmo = q.tmo + `TMO_STEP;
            end
         end
         // follow the phases the target steps through
         st_phase: begin
            if (!b.bsy) begin
               // bus free is only fine after the closing message
               d.atn   = 1'b0;
               d.done  = 1'b1;
               d.busy  = 1'b0;
               d.state = st_idle;
               if (!q.got_msgin) begin
                  d.result.err = unexpected_phase_error;
               end
            end else if (b.req) begin
               d.ack     = 1'b1;
               d.data_oe = 1'b0;
               d.state   = st_ack_wait;
               case (phase)
                  `PH_MSG_OUT: begin
                     // every byte asked for here is a message byte
                     d.data_out = ident;
                     d.data_oe  = 1'b1;
                     d.atn      = 1'b0;
                  end
                  `PH_CMD: begin
                     // pending message is simply dropped if skipped
                     d.atn = 1'b0;
                     if (q.idx < `CDB_LEN) begin
                        d.data_out = q.cdb[q.idx];
                        d.data_oe  = 1'b1;
                        d.idx      = q.idx + `IDX_STEP;
                     end else begin
                        d.ack        = 1'b0;
                        d.done       = 1'b1;
                        d.busy       = 1'b0;
                        d.result.err = unexpected_phase_error;
                        d.state      = st_idle;
                     end
                  end
                  `PH_STATUS: begin
                     d.result.status = b.data;
                  end
                  `PH_MSG_IN: begin
                     d.result.msg_in = b.data;
                     d.got_msgin     = 1'b1;
                  end
                  default: begin
                     // data phases are not served by this block
                     d.ack        = 1'b0;
                     d.atn        = 1'b0;
                     d.done       = 1'b1;
                     d.busy       = 1'b0;
                     d.result.err = unexpected_phase_error;
                     d.state      = st_idle;
                  end
               endcase
            end
         end
         // hold acknowledge until the target drops request
         st_ack_wait: begin
            if (!b.req) begin
               d.ack     = 1'b0;
               d.data_oe = 1'b0;
               d.state   = st_phase;
            end
         end
      endcase
   end

   // state register; enable low freezes everything
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= '0;
      end else if (ce) begin
         q <= d;
      end
   end

   // outputs straight from the state register
   assign busy     = q.busy;
   assign done     = q.done;
   assign result   = q.result;
   assign sel_out  = q.sel;
   assign atn_out  = q.atn;
   assign ack_out  = q.ack;
   assign data_out = q.data_out;
   assign data_oe  = q.data_oe;

   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n || !ce);

   sequence s_diag_go;
      accept && cmd.code == cmd_send_diag && !arg_bad;
   endsequence

   sequence s_req_in(logic [2:0] ph);
      q.state == st_phase && b.bsy && b.req && phase == ph;
   endsequence

   sequence s_arg_reject;
      done && result.err == argument_error && !sel_out;
   endsequence

   property p_sel_atn;
      q.state == st_select && q.cmd != cmd_sel_plain |-> sel_out && atn_out;
   endproperty
   a_sel_atn: assert property (p_sel_atn)
      else $error("attention not held during selection");

   property p_msg_out;
      s_req_in(`PH_MSG_OUT) |=> ack_out && data_oe && data_out == ident
                                && !atn_out;
   endproperty
   a_msg_out: assert property (p_msg_out)
      else $error("message-out byte not sent");

   property p_skip_msg;
      s_req_in(`PH_CMD) ##0 (q.idx == 3'h0 && atn_out) |=> ack_out
         && data_out == `OPC_SEND_DIAG ##1 !atn_out;
   endproperty
   a_skip_msg: assert property (p_skip_msg)
      else $error("command phase not served with pending message");

   property p_sel_plain;
      q.state == st_select && q.cmd == cmd_sel_plain |-> sel_out && !atn_out;
   endproperty
   a_sel_plain: assert property (p_sel_plain)
      else $error("attention asserted in plain select");

   property p_sel_fail;
      q.state == st_select && !b.bsy && q.tmo == TMO_LAST |=> done
         && result.err == selection_failed_error && !sel_out && !busy;
   endproperty
   a_sel_fail: assert property (p_sel_fail)
      else $error("selection timeout not reported");

   property p_sel_trail;
      accept && cmd.code != cmd_send_diag && cmd.trailing |=> s_arg_reject;
   endproperty
   a_sel_trail: assert property (p_sel_trail)
      else $error("trailing text on select not rejected");

   property p_cdb_fixed;
      s_diag_go |=> q.cdb[0] == `OPC_SEND_DIAG && q.cdb[2] == `ZERO_BYTE;
   endproperty
   a_cdb_fixed: assert property (p_cdb_fixed)
      else $error("diagnostic opcode or byte two wrong");

   property p_cdb_len;
      s_diag_go |=> q.cdb[1][4:0] == ($past(val_zero) ? `NO_TEST_BITS
         : `SELF_TEST_BITS) && {q.cdb[3], q.cdb[4]} == ($past(val_zero)
         ? $past(cmd.len) : {`ZERO_BYTE, `ZERO_BYTE});
   endproperty
   a_cdb_len: assert property (p_cdb_len)
      else $error("self-test bits or length bytes wrong");

   property p_cdb_cfg;
      s_diag_go |=> q.cdb[1][7:5] == $past(cfg.lun)
         && q.cdb[5] == {$past(cfg.vcb), `VCB_PAD};
   endproperty
   a_cdb_cfg: assert property (p_cdb_cfg)
      else $error("unit number or control bits wrong");

   property p_bad_phase;
      q.state == st_phase && b.bsy && b.req && phase != `PH_MSG_OUT
         && phase != `PH_CMD && phase != `PH_STATUS && phase != `PH_MSG_IN
         |=> done && result.err == unexpected_phase_error && !ack_out;
   endproperty
   a_bad_phase: assert property (p_bad_phase)
      else $error("unexpected phase not reported");

   property p_no_value;
      accept && cmd.code == cmd_send_diag && !cmd.val_present
         |=> s_arg_reject;
   endproperty
   a_no_value: assert property (p_no_value)
      else $error("missing diagnostic value not rejected");

   property p_no_len;
      accept && cmd.code == cmd_send_diag && val_zero && !cmd.len_present
         |=> s_arg_reject;
   endproperty
   a_no_len: assert property (p_no_len)
      else $error("zero value without length not rejected");

   property p_extra_len;
      accept && cmd.code == cmd_send_diag && !val_zero && cmd.len_present
         |=> s_arg_reject;
   endproperty
   a_extra_len: assert property (p_extra_len)
      else $error("length with nonzero value not rejected");

endmodule // scsi_diag_seq

//--- bench/scsi_target_model.sv
`timescale 1ns/1ps
// behavioural scsi target answering the sequencer's selections
module scsi_target_model
   import scsi_diag_pkg::*;
#(
   parameter logic [7:0] STATUS_BYTE = 8'h02 // status byte it returns
) (
   // clock
   input  wire logic       core_clk,
   // scenario controls
   input  wire logic [2:0] my_id,
   input  wire logic       present,
   input  wire logic       session,
   input  wire logic       msgout_ok,
   input  wire logic       bad_phase,
   // initiator drive
   input  wire logic       sel_out,
   input  wire logic       atn_out,
   input  wire logic       ack_out,
   input  wire logic [7:0] data_out,
   input  wire logic       data_oe,
   // bus seen by the sequencer
   output bus_in_t         bus_in,
   // bytes the target received
   output logic [7:0]      got_msg,
   output logic [7:0]      got_cdb [6],
   output logic [3:0]      n_msg
);
   logic       bsy;  // busy line
   logic       req;  // request line
   logic [2:0] ph;   // {msg, cd, io}
   logic [7:0] tdat; // target data, deasserted once released
   logic [7:0] tmp;  // discarded capture

   // released lines read deasserted, data shows the driver's value
   assign bus_in = {bsy, req, ph, (data_oe ? data_out : tdat)};

   // one req/ack byte, changes only just after a rising edge
   task automatic xfer(input logic [2:0] p, input logic [7:0] d,
                       output logic [7:0] got);
      int i;
      #1 ph = p;
      if (p[0]) tdat = d;
      @(posedge core_clk);
      #1 req = 1'b1;
      for (i = 0; i < 40; i++) begin
         @(posedge core_clk);
         if (ack_out === 1'b1) break;
      end
      got = data_out;
      #1 req = 1'b0;
      tdat = 8'h00; // terminated data lines float to deasserted
      for (i = 0; i < 40; i++) begin
         @(posedge core_clk);
         if (ack_out !== 1'b1) break;
      end
   endtask

   // message out first, then command, status, message in
   task automatic run_session;
      int i;
      n_msg = 4'h0;
      if (msgout_ok && atn_out === 1'b1) begin
         xfer(3'h6, 8'h00, got_msg);
         n_msg = 4'h1;
      end // a target without message out ignores the attention
      for (i = 0; i < 6; i++) xfer(3'h2, 8'h00, got_cdb[i]);
      if (bad_phase) begin
         #1 ph = 3'h0; // data out, never expected here
         @(posedge core_clk);
         #1 req = 1'b1;
         repeat (8) @(posedge core_clk);
         #1 req = 1'b0;
      end else begin
         xfer(3'h3, STATUS_BYTE, tmp);
         xfer(3'h7, 8'h00, tmp);
      end
   endtask

   // answer a selection of our id, then free the bus
   initial begin
      bsy = 1'b0;
      req = 1'b0;
      ph = 3'h0;
      tdat = 8'h00;
      n_msg = 4'h0;
      got_msg = 8'h00;
      forever begin
         @(posedge core_clk);
         if (present && sel_out === 1'b1 && data_oe === 1'b1 &&
             data_out[my_id] === 1'b1) begin
            #1 bsy = 1'b1;
            while (sel_out === 1'b1) @(posedge core_clk);
            if (session) run_session();
            repeat (4) @(posedge core_clk);
            #1 bsy = 1'b0;
            ph = 3'h0;
         end
      end
   end
endmodule // scsi_target_model

//--- bench/test_scsi_select_and_send_diag_cmds.sv
`timescale 1ns/1ps
// self-checking bench for the select and diagnostic sequencer
module test_scsi_select_and_send_diag_cmds;
   import scsi_diag_pkg::*;
   localparam int SEL_TMO = 16;  // short selection timeout
   localparam int LIMIT = 20000; // hang ceiling in cycles
   localparam logic [7:0] STS = 8'h02;

   logic       core_clk, rst_n, ce, cmd_valid, busy, done;
   logic       sel_out, atn_out, ack_out, data_oe;
   logic       present, session, msgout_ok, bad_phase;
   logic [7:0] data_out, got_msg;
   logic [7:0] got_cdb [6];
   logic [3:0] n_msg;
   host_cmd_t  cmd;
   cfg_t       cfg;
   result_t    result;
   bus_in_t    bus_in;
   int         err_total, num_checks, cyc;

   scsi_diag_seq #(.SEL_TMO_CYC(SEL_TMO)) DUT (
      .core_clk(core_clk), .rst_n(rst_n), .ce(ce),
      .cmd_valid(cmd_valid), .cmd(cmd), .cfg(cfg),
      .busy(busy), .done(done), .result(result),
      .bus_in(bus_in), .sel_out(sel_out), .atn_out(atn_out),
      .ack_out(ack_out), .data_out(data_out), .data_oe(data_oe));

   scsi_target_model #(.STATUS_BYTE(STS)) far_end (
      .core_clk(core_clk), .my_id(3'h3), .present(present),
      .session(session), .msgout_ok(msgout_ok), .bad_phase(bad_phase),
      .sel_out(sel_out), .atn_out(atn_out), .ack_out(ack_out),
      .data_out(data_out), .data_oe(data_oe), .bus_in(bus_in),
      .got_msg(got_msg), .got_cdb(got_cdb), .n_msg(n_msg));

   // verdict, the only exit
   task automatic end_of_test;
      if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // compare tasks, one per result kind
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_bit(input logic got, input logic exp);
      chk_byte({7'h00, got}, {7'h00, exp});
   endtask
   task automatic chk_err(input err_code_t got, input err_code_t exp);
      chk_byte({6'h00, got}, {6'h00, exp});
   endtask

   // one-cycle command strobe, held until the taking edge
   task automatic issue(input cmd_code_t c, input logic vp, input logic vo,
                        input logic [7:0] v, input logic lp,
                        input logic [15:0] l, input logic tr);
      @(posedge core_clk);
      #1 cmd = '{c, vp, vo, v, lp, 1'b0, l, tr};
      cmd_valid = 1'b1;
      @(posedge core_clk);
      #1 cmd_valid = 1'b0;
   endtask

   // bounded wait for done, returns cycles spent
   task automatic wait_done(output int n);
      for (n = 0; n < 200 && done !== 1'b1; n++) begin
         @(posedge core_clk);
         #1;
      end
      chk_bit(done, 1'b1);
   endtask

   // let the target free the bus
   task automatic rest;
      repeat (15) @(posedge core_clk);
      #1;
   endtask

   // select with or without attention at target 3
   task automatic t_sel(input cmd_code_t c, input logic atn);
      int n;
      present = 1'b1;
      session = 1'b0;
      issue(c, 1'b0, 1'b0, 8'h00, 1'b0, 16'h0000, 1'b0);
      chk_bit(sel_out, 1'b1);
      chk_bit(data_oe, 1'b1);
      chk_bit(busy, 1'b1);
      chk_bit(atn_out, atn);
      chk_byte(data_out, 8'h08);
      wait_done(n);
      chk_err(result.err, err_none);
      rest();
   endtask

   // nobody at the target id
   task automatic t_nosel(input cmd_code_t c);
      int n;
      present = 1'b0;
      issue(c, 1'b0, 1'b0, 8'h00, 1'b0, 16'h0000, 1'b0);
      wait_done(n);
      chk_bit(n >= SEL_TMO, 1'b1);
      chk_err(result.err, selection_failed_error);
      rest();
   endtask

   // refused command line, answered at once with no bus use
   task automatic t_arg(input cmd_code_t c, input logic vp, input logic vo,
                        input logic [7:0] v, input logic lp,
                        input logic tr);
      issue(c, vp, vo, v, lp, 16'h0001, tr);
      chk_bit(done, 1'b1);
      chk_bit(sel_out, 1'b0);
      chk_err(result.err, argument_error);
      rest();
   endtask

   // full diagnostic, descriptor checked byte by byte
   task automatic t_diag(input logic [7:0] v, input logic lp,
                         input logic [15:0] l, input logic mok);
      int n;
      logic nz;
      nz = (v != 8'h00);
      present = 1'b1;
      session = 1'b1;
      msgout_ok = mok;
      issue(cmd_send_diag, 1'b1, 1'b0, v, lp, l, 1'b0);
      wait_done(n);
      chk_err(result.err, err_none);
      chk_byte(result.status, STS);
      chk_byte(result.msg_in, 8'h00);
      chk_byte({4'h0, n_msg}, {7'h00, mok});
      if (mok) chk_byte(got_msg, {5'h10, cfg.lun});
      chk_byte(got_cdb[0], 8'h1D);
      chk_byte(got_cdb[1], {cfg.lun, nz ? 5'h04 : 5'h00});
      chk_byte(got_cdb[2], 8'h00);
      chk_byte(got_cdb[3], nz ? 8'h00 : l[15:8]);
      chk_byte(got_cdb[4], nz ? 8'h00 : l[7:0]);
      chk_byte(got_cdb[5], {cfg.vcb, 6'h00});
      rest();
   endtask

   // target wanders into a data phase
   task automatic t_badph;
      int n;
      bad_phase = 1'b1;
      issue(cmd_send_diag, 1'b1, 1'b0, 8'h01, 1'b0, 16'h0000, 1'b0);
      wait_done(n);
      chk_err(result.err, unexpected_phase_error);
      bad_phase = 1'b0;
      rest();
   endtask

   // clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // hang guard
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         err_total++;
         end_of_test();
      end
   end

   // main sequence
   initial begin
      err_total = 0;
      num_checks = 0;
      cyc = 0;
      rst_n = 1'b0;
      ce = 1'b1;
      cmd_valid = 1'b0;
      cmd = '0;
      cfg = '{3'h3, 3'h5, 2'b10};
      present = 1'b0;
      session = 1'b0;
      msgout_ok = 1'b1;
      bad_phase = 1'b0;
      repeat (20) @(posedge core_clk);
      #1 rst_n = 1'b1;
      chk_bit(busy, 1'b0);
      t_sel(cmd_sel_atn, 1'b1);
      t_sel(cmd_sel_plain, 1'b0);
      t_nosel(cmd_sel_atn);
      t_nosel(cmd_sel_plain);
      t_arg(cmd_sel_atn, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
      t_arg(cmd_sel_plain, 1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
      t_arg(cmd_send_diag, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
      t_arg(cmd_send_diag, 1'b1, 1'b1, 8'hFF, 1'b0, 1'b0);
      t_arg(cmd_send_diag, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
      t_arg(cmd_send_diag, 1'b1, 1'b0, 8'hFF, 1'b1, 1'b0);
      t_diag(8'hFF, 1'b0, 16'h0000, 1'b1);
      cfg = '{3'h3, 3'h2, 2'b01};
      t_diag(8'h00, 1'b1, 16'hA55A, 1'b0);
      t_badph();
      end_of_test();
   end
endmodule // test_scsi_select_and_send_diag_cmds
